// >>> bench/serial_peer.sv
`timescale 1ns/100ps
module serial_peer (
    input  wire logic       clk_i,
    input  wire logic       send_i,
    input  wire logic [7:0] byte_i,
    input  wire logic       line_i,
    output logic            rxd_o,
    output logic [7:0]      got_o,
    output logic            got_v_o
);
    initial begin
        rxd_o = 1'b1;
        got_o = 8'h00;
        got_v_o = 1'b0;
    end
    // sender: 8N1, lsb first, 16 cycles a bit since the divisor stays 1 until s_div writes 3
    always @(posedge clk_i) if (send_i) begin
        rxd_o <= 1'b0;
        repeat (16) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            rxd_o <= byte_i[i];
            repeat (16) @(posedge clk_i);
        end
        rxd_o <= 1'b1;
    end
    // receiver: samples mid-bit; busy block ignores edges inside the frame
    always @(negedge line_i) begin
        got_v_o = 1'b0;
        repeat (8) @(posedge clk_i);
        for (int k = 0; k < 8; k++) begin
            repeat (16) @(posedge clk_i);
            got_o[k] = line_i;
        end
        repeat (16) @(posedge clk_i);
        got_v_o = line_i;
    end
endmodule : serial_peer

// >>> bench/tb.sv
`timescale 1ns/100ps
module tb;
    import uart_pkg::*;
    logic        clk, nrst, psel, pen, pwr, send, lp, low, e;
    logic [7:0]  paddr, sbyte, gb;
    logic [31:0] pwd, prd, r;
    logic        prdy, perr, serial_in, serial_out, tick, irq, gv;
    int          fail_count, n_tests, cyc;
    uart_data_buffers DUT (.core_clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd), .pstrb_i(4'hF), .prdata_o(prd),
        .pready_o(prdy), .pslverr_o(perr), .serial_in_i(serial_in), .serial_out_o(serial_out),
        .baud_tick_out_o(tick), .irq_o(irq));
    serial_peer peer (.clk_i(clk), .send_i(send), .byte_i(sbyte), .line_i(serial_out),
        .rxd_o(serial_in), .got_o(gb), .got_v_o(gv));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // watch for any low bit on the line while looped back
    always @(posedge clk) if (lp && serial_out !== 1'b1) low <= 1'b1;
    // hang guard: the whole run needs about a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, x);
        end
    endtask : chk
    // apb master: setup, access held until pready sampled high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (prdy !== 1'b1);
        r = prd;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk); // idle cycle: next setup never shares this time step
    endtask : bus
    task automatic s_regs;
        bus(1'b1, OFS_SCRATCH, 32'h5A);
        bus(1'b0, OFS_SCRATCH, 32'h0);
        chk(r, 32'h5A);
        bus(1'b0, 8'h40, 32'h0);
        chk({e, r[30:0]}, 32'h80000000);
    endtask : s_regs
    task automatic s_irq;
        bus(1'b0, OFS_IRQ_STAT, 32'h0);
        chk(r, 32'h2);
        chk(32'(irq), 32'h0);
        bus(1'b1, OFS_IRQ_EN, 32'h2);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h1);
        bus(1'b1, OFS_IRQ_EN, 32'h0);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
    endtask : s_irq
    task automatic s_tx;
        bus(1'b1, OFS_IRQ_EN, 32'h2);
        bus(1'b1, OFS_TX_HOLD, 32'hA5);
        for (int k = 0; k < 400 && gv !== 1'b1; k++) @(posedge clk);
        chk({24'h0, gb}, 32'hA5);
        chk(32'(irq), 32'h1);
    endtask : s_tx
    task automatic s_rx;
        bus(1'b1, OFS_IRQ_EN, 32'h1);
        sbyte <= 8'h3C;
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        for (int k = 0; k < 400 && irq !== 1'b1; k++) @(posedge clk);
        chk(32'(irq), 32'h1);
        bus(1'b0, OFS_RX_BUF, 32'h0);
        chk(r, 32'h3C);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
    endtask : s_rx
    // fifo mode in loopback: three chars queue, return in order, line held high
    task automatic s_loop;
        bus(1'b1, OFS_FIFO_CTRL, 32'h01);
        bus(1'b1, OFS_LINE_CTRL, 32'h2F); // odd parity, two stops
        @(posedge clk);
        lp <= 1'b1;
        for (int k = 1; k < 4; k++) bus(1'b1, OFS_TX_HOLD, 32'h11 * k);
        for (int k = 0; k < 400; k++) begin
            bus(1'b0, OFS_LINE_STAT, 32'h0);
            if (r[LS_TEMT] === 1'b1) break;
        end
        chk(r, 32'h61);
        chk(32'(low), 32'h0);
        chk(32'(irq), 32'h1);
        for (int k = 1; k < 4; k++) begin
            bus(1'b0, OFS_RX_BUF, 32'h0);
            chk(r, 32'h11 * k);
        end
        bus(1'b1, OFS_IRQ_CLR, 32'h1);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
    endtask : s_loop
    // divisor 3: reload restarts the count, then a tick every third cycle
    task automatic s_div;
        int k;
        bus(1'b1, OFS_DIVISOR, 32'h3);
        @(posedge clk);
        for (k = 0; k < 20 && tick !== 1'b1; k++) @(posedge clk);
        chk(k, 32'h3);
        @(posedge clk);
        for (k = 0; k < 20 && tick !== 1'b1; k++) @(posedge clk);
        chk(k, 32'h2);
        bus(1'b0, OFS_DIVISOR, 32'h0);
        chk(r, 32'h3);
    endtask : s_div
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report
    initial begin
        {nrst, psel, pen, pwr, send, lp, low} = 7'h00;
        {paddr, sbyte, pwd} = 48'h0;
        {fail_count, n_tests, cyc} = 96'h0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        s_regs();
        s_irq();
        s_tx();
        s_rx();
        s_loop();
        s_div();
        final_report();
    end
endmodule : tb

// >>> include/uart_pkg.sv
package uart_pkg;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0]  OFS_RX_BUF    = 8'h00;
    localparam logic [7:0]  OFS_TX_HOLD   = 8'h04;
    localparam logic [7:0]  OFS_SCRATCH   = 8'h08;
    localparam logic [7:0]  OFS_LINE_CTRL = 8'h0C;
    localparam logic [7:0]  OFS_FIFO_CTRL = 8'h10;
    localparam logic [7:0]  OFS_DIVISOR   = 8'h14;
    localparam logic [7:0]  OFS_IRQ_STAT  = 8'h18;
    localparam logic [7:0]  OFS_IRQ_CLR   = 8'h1C;
    localparam logic [7:0]  OFS_IRQ_EN    = 8'h20;
    localparam logic [7:0]  OFS_LINE_STAT = 8'h24;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int LC_LEN      = 0;
    localparam int LC_STOP2    = 2;
    localparam int LC_PAR_EN   = 3;
    localparam int LC_PAR_EVEN = 4;
    localparam int LC_LOOP     = 5;
    localparam int FC_FIFO_EN  = 0;
    localparam int FC_TRIG     = 6;
    localparam int IRQ_RX      = 0;
    localparam int IRQ_TX      = 1;
    localparam int IRQ_OVR     = 2;
    localparam int IRQ_ERR     = 3;
    localparam int LS_DR       = 0;
    localparam int LS_TX_HOLDING_EMPTY     = 5;
    localparam int LS_TEMT     = 6;
    // ----------------------------------------------------------------
    // reset values and timing counts
    // ----------------------------------------------------------------
    localparam logic [7:0]  LC_RST    = 8'h03;
    localparam logic [7:0]  FC_RST    = 8'h00;
    localparam logic [15:0] DIV_RST   = 16'h0001;
    localparam logic [7:0]  SCR_RST   = 8'h00;
    localparam logic [3:0]  STAT_RST  = 4'h2;
    localparam logic [3:0]  TICK_MID  = 4'h7;
    localparam logic [3:0]  TICK_LAST = 4'hF;
    localparam logic [2:0]  LEN_BASE  = 3'h4;
    localparam logic [4:0]  TRIG_1    = 5'h01;
    localparam logic [4:0]  TRIG_4    = 5'h04;
    localparam logic [4:0]  TRIG_8    = 5'h08;
    localparam logic [4:0]  TRIG_14   = 5'h0E;
    // ----------------------------------------------------------------
    // state types
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        RX_IDLE = 5'b00001, RX_START = 5'b00010, RX_DATA = 5'b00100,
        RX_PAR  = 5'b01000, RX_STOP  = 5'b10000
    } rx_state_t;
    typedef enum logic [4:0] {
        TX_IDLE = 5'b00001, TX_START = 5'b00010, TX_DATA = 5'b00100,
        TX_PAR  = 5'b01000, TX_STOP  = 5'b10000
    } tx_state_t;
endpackage : uart_pkg

// >>> rtl/baud_gen.sv
`timescale 1ns/100ps
module baud_gen #(
    parameter int DW = 16
) (
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic [DW-1:0] divisor_i,
    input  wire logic          reload_i,
    output wire logic          tick_o
);
    logic [DW-1:0] cnt_q;
    logic          tick_q;

    // divisor 0 behaves as 1, so the tick never stops
    wire wrap = (cnt_q <= DW'(1));

    assign tick_o = tick_q;

    // a reload restarts the count at once, avoiding a long first count
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= (reload_i | wrap) ? divisor_i : cnt_q - DW'(1);
            tick_q <= wrap & ~reload_i;
        end
    end
endmodule : baud_gen

// >>> rtl/byte_fifo.sv
`timescale 1ns/100ps
module byte_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          clear_i,
    input  wire logic          one_deep_i,
    input  wire logic          push_i,
    input  wire logic [W-1:0]  data_i,
    input  wire logic          pop_i,
    output wire logic [W-1:0]  data_o,
    output wire logic [AW:0]   count_o,
    output wire logic          full_o,
    output wire logic          empty_o
);
    logic [W-1:0]  mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   cnt_q;

    // one-deep mode pins both pointers to the first entry
    wire [AW-1:0] wa     = one_deep_i ? '0 : wr_q;
    wire [AW-1:0] ra     = one_deep_i ? '0 : rd_q;
    wire          do_push = push_i & ~full_o;
    wire          do_pop  = pop_i & ~empty_o;

    assign full_o  = one_deep_i ? (cnt_q != '0) : (cnt_q == (AW+1)'(DEPTH));
    assign empty_o = (cnt_q == '0);
    assign count_o = cnt_q;
    assign data_o  = mem_q[ra];

    // storage, written only on an accepted push
    always_ff @(posedge clk_i) begin
        if (do_push) mem_q[wa] <= data_i;
    end

    // pointers and fill count
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (clear_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_q + AW'(do_push);
            rd_q  <= rd_q + AW'(do_pop);
            cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule : byte_fifo

// >>> rtl/uart_data_buffers.sv
// Contract
// R01 - receive buffer is sixteen byte FIFO
// R02 - receiver timed by 16x tick, line control
// R03 - serial input shifted, assembled, pushed
// R04 - char mode: received char raises interrupt
// R05 - char mode: reading buffer clears interrupt
// R06 - FIFO mode: interrupts follow FIFO control
// R07 - scratch byte freely readable and writable
// R08 - transmit holding is sixteen byte FIFO
// R09 - transmitter timed by baud tick
// R10 - line control governs transmitter framing
// R11 - load shift register only when idle
// R12 - shift register serialised onto output
// R13 - char mode: holding empty raises interrupt
// R14 - char mode: loading holding clears interrupt
// R15 - baud divider divides by 1..65535
// R16 - divisor write reloads baud counter immediately
// R17 - loopback feeds transmitter to receiver, output high
// R18 - char mode uses first FIFO entry only
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/100ps
module uart_data_buffers
    import uart_pkg::*;
#(
    parameter int DEPTH = 16
) (
    input  wire logic        core_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output wire logic [31:0] prdata_o,
    output wire logic        pready_o,
    output wire logic        pslverr_o,
    input  wire logic        serial_in_i,
    output wire logic        serial_out_o,
    output wire logic        baud_tick_out_o,
    output wire logic        irq_o
);
    localparam int AW = $clog2(DEPTH);

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_q;
    wire        rst_n_q = rst_sync_q[1];

    // async assert, two-stage release
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) rst_sync_q <= 2'b00;
        else rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    // ----------------------------------------------------------------
    // register bus decode
    // ----------------------------------------------------------------
    logic [7:0]  line_ctrl_q;
    logic [7:0]  fifo_ctrl_q;
    logic [15:0] div_q;
    logic [7:0]  scratch_q;
    logic [3:0]  stat_q;
    logic [3:0]  irq_en_q;
    logic        div_load_q;

    wire acc       = psel_i & penable_i;
    wire wr        = acc & pwrite_i;
    wire rd        = acc & ~pwrite_i;
    wire hit_rx    = (paddr_i == OFS_RX_BUF);
    wire hit_tx    = (paddr_i == OFS_TX_HOLD);
    wire hit_scr   = (paddr_i == OFS_SCRATCH);
    wire hit_lc    = (paddr_i == OFS_LINE_CTRL);
    wire hit_fc    = (paddr_i == OFS_FIFO_CTRL);
    wire hit_div   = (paddr_i == OFS_DIVISOR);
    wire hit_stat  = (paddr_i == OFS_IRQ_STAT);
    wire hit_clr   = (paddr_i == OFS_IRQ_CLR);
    wire hit_en    = (paddr_i == OFS_IRQ_EN);
    wire hit_ls    = (paddr_i == OFS_LINE_STAT);
    wire mapped    = hit_rx | hit_tx | hit_scr | hit_lc | hit_fc | hit_div
                   | hit_stat | hit_clr | hit_en | hit_ls;
    wire div_wr    = wr & hit_div & (pstrb_i[0] | pstrb_i[1]);
    wire fc_change = wr & hit_fc & (pwdata_i[FC_FIFO_EN] != fifo_ctrl_q[FC_FIFO_EN]);
    wire rx_read   = rd & hit_rx;
    wire tx_write  = wr & hit_tx;
    wire irq_clr_w = wr & hit_clr;

    // mode and framing fields
    wire       fifo_mode = fifo_ctrl_q[FC_FIFO_EN];
    wire       loop      = line_ctrl_q[LC_LOOP];
    wire [1:0] lc_len    = line_ctrl_q[LC_LEN +: 2];
    wire       par_en    = line_ctrl_q[LC_PAR_EN];
    wire       par_even  = line_ctrl_q[LC_PAR_EVEN];
    wire       stop2     = line_ctrl_q[LC_STOP2];
    wire [2:0] last_idx  = LEN_BASE + {1'b0, lc_len};
    wire [1:0] trig_sel  = fifo_ctrl_q[FC_TRIG +: 2];
    wire [4:0] trig_lvl  = (trig_sel == 2'd0) ? TRIG_1 :
                           (trig_sel == 2'd1) ? TRIG_4 :
                           (trig_sel == 2'd2) ? TRIG_8 : TRIG_14;

    assign pready_o  = 1'b1;
    assign pslverr_o = acc & ~mapped;

    // software-written registers; none of them has a read side effect
    always_ff @(posedge core_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            line_ctrl_q <= LC_RST;
            fifo_ctrl_q <= FC_RST;
            scratch_q   <= SCR_RST;
            irq_en_q    <= '0;
        end else begin
            if (wr & hit_lc)  line_ctrl_q <= pwdata_i[7:0];
            if (wr & hit_fc)  fifo_ctrl_q <= pwdata_i[7:0];
            if (wr & hit_scr) scratch_q   <= pwdata_i[7:0]; // [R07]
            if (wr & hit_en)  irq_en_q    <= pwdata_i[3:0];
        end
    end

    // divisor bytes by lane; the counter reload follows one cycle later
    always_ff @(posedge core_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            div_q      <= DIV_RST;
            div_load_q <= 1'b0;
        end else begin
            if (wr & hit_div & pstrb_i[0]) div_q[7:0]  <= pwdata_i[7:0];
            if (wr & hit_div & pstrb_i[1]) div_q[15:8] <= pwdata_i[15:8];
            div_load_q <= div_wr; // [R16]
        end
    end

    // ----------------------------------------------------------------
    // baud tick and buffers
    // ----------------------------------------------------------------
    wire          baud_tick;
    wire [7:0]    rx_head;
    wire [7:0]    tx_head;
    wire [AW:0]   rx_count;
    wire [AW:0]   tx_count;
    wire          rx_full;
    wire          rx_empty;
    wire          tx_full;
    wire          tx_empty;
    logic [7:0]   rx_char;
    logic         rx_push;
    logic         tx_pop;

    assign baud_tick_out_o = baud_tick;

    baud_gen #(.DW(16)) u_baud ( // [R15]
        .clk_i     (core_clk_i),
        .rst_n_i   (rst_n_q),
        .divisor_i (div_q),
        .reload_i  (div_load_q),
        .tick_o    (baud_tick)
    );

    // one-deep in character mode; a mode change flushes both stores
    byte_fifo #(.W(8), .DEPTH(DEPTH)) u_rx_fifo ( // [R01] [R18]
        .clk_i      (core_clk_i),
        .rst_n_i    (rst_n_q),
        .clear_i    (fc_change),
        .one_deep_i (~fifo_mode),
        .push_i     (rx_push),
        .data_i     (rx_char),
        .pop_i      (rx_read),
        .data_o     (rx_head),
        .count_o    (rx_count),
        .full_o     (rx_full),
        .empty_o    (rx_empty)
    );

    byte_fifo #(.W(8), .DEPTH(DEPTH)) u_tx_fifo ( // [R08] [R18]
        .clk_i      (core_clk_i),
        .rst_n_i    (rst_n_q),
        .clear_i    (fc_change),
        .one_deep_i (~fifo_mode),
        .push_i     (tx_write),
        .data_i     (pwdata_i[7:0]),
        .pop_i      (tx_pop),
        .data_o     (tx_head),
        .count_o    (tx_count),
        .full_o     (tx_full),
        .empty_o    ()
    );

    // ----------------------------------------------------------------
    // transmitter
    // ----------------------------------------------------------------
    tx_state_t tx_state_q;
    logic [3:0] tx_tick_q;
    logic [2:0] tx_idx_q;
    logic [7:0] tx_sr_q;
    logic       tx_par_q;
    logic       tx_stop2_q;
    logic       tx_line_q;
    logic       serial_out_q;
    logic       tx_line_d;

    wire tx_bit_end = baud_tick & (tx_tick_q == TICK_LAST); // [R09]
    assign tx_pop   = baud_tick & (tx_state_q == TX_IDLE) & ~tx_empty; // [R11]
    assign tx_empty = (tx_count == '0);

    // line level per state; odd parity inverts the running xor
    always_comb begin
        case (tx_state_q)
            TX_START: tx_line_d = 1'b0;
            TX_DATA:  tx_line_d = tx_sr_q[0]; // [R12]
            TX_PAR:   tx_line_d = tx_par_q ^ ~par_even; // [R10]
            default:  tx_line_d = 1'b1;
        endcase
    end

    // framing sequencer, advanced only on baud ticks
    always_ff @(posedge core_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tx_state_q <= TX_IDLE;
            tx_tick_q  <= '0;
            tx_idx_q   <= '0;
            tx_sr_q    <= '0;
            tx_par_q   <= 1'b0;
            tx_stop2_q <= 1'b0;
        end else if (baud_tick) begin
            tx_tick_q <= tx_tick_q + 4'd1;
            case (tx_state_q)
                TX_IDLE: begin
                    tx_tick_q <= '0;
                    if (tx_pop) begin
                        tx_sr_q    <= tx_head;
                        tx_par_q   <= 1'b0;
                        tx_idx_q   <= '0;
                        tx_stop2_q <= 1'b0;
                        tx_state_q <= TX_START;
                    end
                end
                TX_START: if (tx_bit_end) tx_state_q <= TX_DATA;
                TX_DATA: if (tx_bit_end) begin
                    tx_sr_q  <= {1'b0, tx_sr_q[7:1]};
                    tx_par_q <= tx_par_q ^ tx_sr_q[0];
                    tx_idx_q <= tx_idx_q + 3'd1;
                    if (tx_idx_q == last_idx) // [R10]
                        tx_state_q <= par_en ? TX_PAR : TX_STOP;
                end
                TX_PAR: if (tx_bit_end) tx_state_q <= TX_STOP;
                TX_STOP: if (tx_bit_end) begin
                    if (stop2 & ~tx_stop2_q) tx_stop2_q <= 1'b1;
                    else tx_state_q <= TX_IDLE;
                end
                default: tx_state_q <= TX_IDLE;
            endcase
        end
    end

    // registered line; loopback parks the pin at mark
    always_ff @(posedge core_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tx_line_q    <= 1'b1;
            serial_out_q <= 1'b1;
        end else begin
            tx_line_q    <= tx_line_d;
            serial_out_q <= loop | tx_line_d; // [R17]
        end
    end

    assign serial_out_o = serial_out_q;

    // ----------------------------------------------------------------
    // receiver
    // ----------------------------------------------------------------
    rx_state_t rx_state_q;
    logic [3:0] rx_tick_q;
    logic [2:0] rx_idx_q;
    logic [7:0] rx_sr_q;
    logic       rx_par_q;
    logic       rx_perr_q;

    wire rx_line    = loop ? tx_line_q : serial_in_i; // [R17]
    wire rx_tick    = baud_tick; // [R02]
    wire rx_bit_end = rx_tick & (rx_tick_q == TICK_LAST);
    wire rx_ferr    = ~rx_line;
    wire rx_err     = rx_ferr | rx_perr_q;
    wire rx_push_ok = rx_push & ~rx_full;

    // short characters arrive at the top; right-justify on push
    assign rx_char = rx_sr_q >> (2'd3 - lc_len); // [R03]
    assign rx_push = (rx_state_q == RX_STOP) & rx_bit_end; // [R03]

    // start bit is rechecked mid-bit, later bits sampled mid-cell
    always_ff @(posedge core_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rx_state_q <= RX_IDLE;
            rx_tick_q  <= '0;
            rx_idx_q   <= '0;
            rx_sr_q    <= '0;
            rx_par_q   <= 1'b0;
            rx_perr_q  <= 1'b0;
        end else if (rx_tick) begin // [R02]
            rx_tick_q <= rx_tick_q + 4'd1;
            case (rx_state_q)
                RX_IDLE: begin
                    rx_tick_q <= '0;
                    if (!rx_line) rx_state_q <= RX_START;
                end
                RX_START: if (rx_tick_q == TICK_MID) begin
                    rx_tick_q  <= '0;
                    rx_idx_q   <= '0;
                    rx_par_q   <= 1'b0;
                    rx_perr_q  <= 1'b0;
                    rx_state_q <= rx_line ? RX_IDLE : RX_DATA; // false start
                end
                RX_DATA: if (rx_bit_end) begin
                    rx_sr_q  <= {rx_line, rx_sr_q[7:1]}; // [R03]
                    rx_par_q <= rx_par_q ^ rx_line;
                    rx_idx_q <= rx_idx_q + 3'd1;
                    if (rx_idx_q == last_idx) // [R02]
                        rx_state_q <= par_en ? RX_PAR : RX_STOP;
                end
                RX_PAR: if (rx_bit_end) begin
                    rx_perr_q  <= rx_par_q ^ rx_line ^ ~par_even;
                    rx_state_q <= RX_STOP;
                end
                RX_STOP: if (rx_bit_end) rx_state_q <= RX_IDLE;
                default: rx_state_q <= RX_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // interrupt status
    // ----------------------------------------------------------------
    wire [4:0] rx_next = rx_count + 5'd1;
    // fifo mode fires at the trigger level, character mode per char
    wire rx_set = rx_push_ok & (fifo_mode ? (rx_next >= trig_lvl) : 1'b1); // [R04] [R06]
    wire tx_set = tx_pop & (tx_count == 5'd1); // [R13] [R06]
    wire [3:0] ev_set = {rx_push & rx_err, rx_push & rx_full, tx_set, rx_set};
    wire [3:0] ev_clr = (irq_clr_w ? pwdata_i[3:0] : 4'h0)
                      | {2'b00, ~fifo_mode & tx_write, ~fifo_mode & rx_read}; // [R05] [R14]

    // set beats clear in the same cycle
    always_ff @(posedge core_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) stat_q <= STAT_RST;
        else stat_q <= (stat_q & ~ev_clr) | ev_set;
    end

    assign irq_o = |(stat_q & irq_en_q); // [R04] [R13]

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    wire [7:0] line_stat = {1'b0, tx_empty & (tx_state_q == TX_IDLE), tx_empty,
                            2'b00, stat_q[IRQ_ERR], stat_q[IRQ_OVR], ~rx_empty};

    assign prdata_o = {32{rd}} & (
          ({32{hit_rx}}   & {24'h0, rx_empty ? 8'h00 : rx_head})
        | ({32{hit_scr}}  & {24'h0, scratch_q})
        | ({32{hit_lc}}   & {24'h0, line_ctrl_q})
        | ({32{hit_fc}}   & {24'h0, fifo_ctrl_q})
        | ({32{hit_div}}  & {16'h0, div_q})
        | ({32{hit_stat}} & {28'h0, stat_q})
        | ({32{hit_en}}   & {28'h0, irq_en_q})
        | ({32{hit_ls}}   & {24'h0, line_stat}));

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_q);

    chk_rx_depth_bound: assert property ( // [R01]
        rx_count <= 5'd16 && tx_count <= 5'd16)
        else $error("fifo count above sixteen");
    chk_char_one_deep: assert property ( // [R18]
        !fifo_mode && !fc_change |-> rx_count <= 5'd1 && tx_count <= 5'd1)
        else $error("character mode store holds more than one");
    chk_rx_irq_set: assert property ( // [R04]
        !fifo_mode && rx_push_ok |=> stat_q[IRQ_RX])
        else $error("received char did not flag interrupt");
    chk_rx_irq_clear: assert property ( // [R05]
        !fifo_mode && rx_read && !rx_set |=> !stat_q[IRQ_RX])
        else $error("buffer read did not clear rx flag");
    chk_tx_irq_clear: assert property ( // [R14]
        !fifo_mode && tx_write && !tx_set |=> !stat_q[IRQ_TX])
        else $error("holding load did not clear tx flag");
    chk_fifo_trigger: assert property ( // [R06]
        fifo_mode && !stat_q[IRQ_RX] && rx_push_ok && rx_next < trig_lvl
        && !(wr & hit_fc) |=> !stat_q[IRQ_RX])
        else $error("rx flag raised below trigger level");
    chk_tx_load_idle: assert property ( // [R11]
        tx_pop |-> tx_state_q == TX_IDLE ##1 tx_state_q == TX_START)
        else $error("shift register loaded while busy");
    chk_start_bit_low: assert property ( // [R12]
        tx_pop |=> !tx_line_d [*8])
        else $error("start bit not driven low");
    chk_loop_mark: assert property ( // [R17]
        loop |=> serial_out_o)
        else $error("serial output not high in loopback");
    chk_irq_output: assert property ( // [R13]
        stat_q[IRQ_TX] && irq_en_q[IRQ_TX] |-> irq_o)
        else $error("holding empty did not raise interrupt");
    chk_baud_reload: assert property ( // [R16]
        div_wr && pwdata_i[15:0] == 16'h0003 && pstrb_i[1:0] == 2'b11
        |=> ##1 !baud_tick ##1 !baud_tick ##1 !baud_tick ##1 baud_tick)
        else $error("divisor write did not restart count");
    chk_scratch_store: assert property ( // [R07]
        wr && hit_scr |=> scratch_q == $past(pwdata_i[7:0]) && $stable(line_ctrl_q))
        else $error("scratch write lost or leaked");
endmodule : uart_data_buffers
